/* design/gpt_timer.sv */
// gated prescaled 16-bit timer/counter with an AXI4-Lite register slave
// assumes inputs synchronous to aclk except external_count_input, which
// is sampled here; idle_mode comes from the device power control
////////////////////////////////////////////////////////////////////////
// Overview of operation
// - one 16-bit counter: timer, synchronous counter or asynchronous counter
// - interrupt on period match and on falling edge of the gate input
// - control bit 15 starts the counter when one, stops it when zero
// - control bit 13 set halts the timer in idle; clear keeps running
// - control bit 6 enables gated accumulation only with internal clock
// - bits 5-4 prescale: 11 1:256, 10 1:64, 01 1:8, 00 1:1
// - bit 2 synchronises external clock when external source selected
// - bit 1 one counts external rising edges, zero counts clock/2
// - control write while running resets prescaler; software avoids it
// - unimplemented control bits 14, 12-7, 3, 0 read as zero
// - usable as clock time base or free-running interval timer
//
// Implementation choices: the register addresses and the AXI4-Lite register port.
module gpt_timer (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [4:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [4:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        external_count_input,
    input  wire logic        idle_mode,
    output logic             irq
);
    gpt_pkg::gpt_state_t st;
    gpt_pkg::gpt_state_t next_st;

    logic [7:0]  ps_term;
    logic        int_tick;
    logic        ext_edge;
    logic        src_tick;
    logic        active;
    logic        tick;
    logic        gate_fall;
    logic        wr_go;
    logic        rd_go;
    logic [15:0] ctrl_rd;
    logic [15:0] ctrl_wr;

    ////////////////////////////////////////////////////////////////////
    // control register image; unimplemented bits stay zero
    always_comb begin
        ctrl_rd = gpt_pkg::CTRL_RESET;
        ctrl_rd[gpt_pkg::BIT_RUN]   = st.ctrl.run;
        ctrl_rd[gpt_pkg::BIT_IDLE]  = st.ctrl.idle_stop_select;
        ctrl_rd[gpt_pkg::BIT_GATE]  = st.ctrl.gated_accumulate_enable;
        ctrl_rd[gpt_pkg::BIT_PS_HI:gpt_pkg::BIT_PS_LO] =
            st.ctrl.prescale_select;
        ctrl_rd[gpt_pkg::BIT_SYNC]  = st.ctrl.external_sync_select;
        ctrl_rd[gpt_pkg::BIT_CS]    = st.ctrl.clock_source_select;
        ctrl_wr = st.wdata[15:0] & gpt_pkg::CTRL_WMASK;
    end

    // tick source selection and prescale terminal
    always_comb begin
        case (st.ctrl.prescale_select)
            2'h0:    ps_term = gpt_pkg::PS_DIV1;
            2'h1:    ps_term = gpt_pkg::PS_DIV8;
            2'h2:    ps_term = gpt_pkg::PS_DIV64;
            default: ps_term = gpt_pkg::PS_DIV256;
        endcase
        int_tick  = st.half_clk;
        // synced path uses the second stage; unsynced the first stage
        // stays inside the sync chain, so async mode looks one stage less
        ext_edge  = st.ctrl.external_sync_select
                  ? (st.ext_sync[1] & ~st.ext_prev)
                  : (st.ext_sync[0] & ~st.ext_sync[1]);
        src_tick  = st.ctrl.clock_source_select ? ext_edge : int_tick;
        active    = st.ctrl.run
                  & ~(idle_mode & st.ctrl.idle_stop_select);
        if (st.ctrl.gated_accumulate_enable
            && !st.ctrl.clock_source_select) begin
            active = active & st.ext_sync[1];
        end
        tick      = active && src_tick && (st.prescale == ps_term);
        gate_fall = st.ctrl.run && st.ctrl.gated_accumulate_enable
                  && !st.ctrl.clock_source_select
                  && st.gate_prev && !st.ext_sync[1];
        wr_go     = st.have_aw && st.have_w && !st.bvalid;
        rd_go     = s_axi_arvalid && st.arready;
    end

    ////////////////////////////////////////////////////////////////////
    // next state: counter, prescaler, registers and bus slave
    always_comb begin
        next_st = st;
        next_st.half_clk = ~st.half_clk;
        next_st.ext_sync = {st.ext_sync[0], external_count_input};
        next_st.ext_prev = st.ext_sync[1];
        next_st.gate_prev = st.ext_sync[1];
        // prescaler advances on each source tick while active
        if (active && src_tick) begin
            next_st.prescale = (st.prescale == ps_term)
                             ? 8'h00 : st.prescale + 8'h01;
        end
        if (tick) begin
            if (st.count == st.period_value) begin
                next_st.count = 16'h0000;
            end else begin
                next_st.count = st.count + 16'h0001;
            end
        end
        // write address and data captured in either order
        next_st.awready = 1'b0;
        next_st.wready  = 1'b0;
        if (s_axi_awvalid && st.awready) begin
            next_st.have_aw = 1'b1;
            next_st.waddr   = s_axi_awaddr;
        end else if (!st.have_aw && !s_axi_awvalid) begin
            next_st.awready = 1'b0;
        end
        if (s_axi_wvalid && st.wready) begin
            next_st.have_w = 1'b1;
            next_st.wdata  = s_axi_wdata;
            next_st.wstrb  = s_axi_wstrb;
        end
        next_st.awready = !next_st.have_aw && !st.bvalid
                        && !(s_axi_awvalid && st.awready);
        next_st.wready  = !next_st.have_w && !st.bvalid
                        && !(s_axi_wvalid && st.wready);
        // status clear-on-one loses to a same-cycle hardware set
        if (wr_go) begin
            next_st.have_aw = 1'b0;
            next_st.have_w  = 1'b0;
            next_st.bvalid  = 1'b1;
            next_st.bresp   = gpt_pkg::RESP_OKAY;
            case (st.waddr)
                gpt_pkg::ADDR_W'(gpt_pkg::OFF_CONTROL): begin
                    if (st.wstrb[0]) begin
                        next_st.ctrl.gated_accumulate_enable =
                            ctrl_wr[gpt_pkg::BIT_GATE];
                        next_st.ctrl.prescale_select =
                            ctrl_wr[gpt_pkg::BIT_PS_HI:gpt_pkg::BIT_PS_LO];
                        next_st.ctrl.external_sync_select =
                            ctrl_wr[gpt_pkg::BIT_SYNC];
                        next_st.ctrl.clock_source_select =
                            ctrl_wr[gpt_pkg::BIT_CS];
                    end
                    if (st.wstrb[1]) begin
                        next_st.ctrl.run = ctrl_wr[gpt_pkg::BIT_RUN];
                        next_st.ctrl.idle_stop_select =
                            ctrl_wr[gpt_pkg::BIT_IDLE];
                    end
                    if (st.ctrl.run) begin
                        next_st.prescale = 8'h00;
                    end
                end
                gpt_pkg::ADDR_W'(gpt_pkg::OFF_COUNT): begin
                    if (st.wstrb[0]) next_st.count[7:0] = st.wdata[7:0];
                    if (st.wstrb[1]) next_st.count[15:8] = st.wdata[15:8];
                end
                gpt_pkg::ADDR_W'(gpt_pkg::OFF_PERIOD): begin
                    if (st.wstrb[0]) begin
                        next_st.period_value[7:0] = st.wdata[7:0];
                    end
                    if (st.wstrb[1]) begin
                        next_st.period_value[15:8] = st.wdata[15:8];
                    end
                end
                gpt_pkg::ADDR_W'(gpt_pkg::OFF_STATUS): begin
                    if (st.wstrb[0]) begin
                        next_st.status = st.status
                            & ~st.wdata[gpt_pkg::ST_W-1:0];
                    end
                end
                gpt_pkg::OFF_MASK: begin
                    if (st.wstrb[0]) begin
                        next_st.mask = st.wdata[gpt_pkg::ST_W-1:0];
                    end
                end
                default: next_st.bresp = gpt_pkg::RESP_SLVERR;
            endcase
        end
        // hardware sets come after the clear so that a set always wins
        if (tick && st.count == st.period_value) begin
            next_st.status[gpt_pkg::ST_MATCH] = 1'b1;
        end
        if (gate_fall) begin
            next_st.status[gpt_pkg::ST_GATE] = 1'b1;
        end
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end
        // read channel: one cycle to accept, data held until rready
        if (rd_go) begin
            next_st.arready = 1'b0;
            next_st.rvalid  = 1'b1;
            next_st.rresp   = gpt_pkg::RESP_OKAY;
            next_st.rdata   = 32'h0000_0000;
            case (s_axi_araddr)
                gpt_pkg::ADDR_W'(gpt_pkg::OFF_CONTROL):
                    next_st.rdata[15:0] = ctrl_rd;
                gpt_pkg::ADDR_W'(gpt_pkg::OFF_COUNT):
                    next_st.rdata[15:0] = st.count;
                gpt_pkg::ADDR_W'(gpt_pkg::OFF_PERIOD):
                    next_st.rdata[15:0] = st.period_value;
                gpt_pkg::ADDR_W'(gpt_pkg::OFF_STATUS):
                    next_st.rdata[gpt_pkg::ST_W-1:0] = st.status;
                gpt_pkg::OFF_MASK:
                    next_st.rdata[gpt_pkg::ST_W-1:0] = st.mask;
                default: next_st.rresp = gpt_pkg::RESP_SLVERR;
            endcase
        end else if (st.rvalid && s_axi_rready) begin
            next_st.rvalid  = 1'b0;
            next_st.arready = 1'b1;
        end
        next_st.irq = |(next_st.status & next_st.mask);
    end

    ////////////////////////////////////////////////////////////////////
    // state register with synchronous active-low reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st              <= '0;
            st.ctrl         <= '0;
            st.period_value <= gpt_pkg::PERIOD_RESET;
            st.awready      <= 1'b1;
            st.wready       <= 1'b1;
            st.arready      <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from flip-flops
    assign s_axi_awready = st.awready;
    assign s_axi_wready  = st.wready;
    assign s_axi_bvalid  = st.bvalid;
    assign s_axi_bresp   = st.bresp;
    assign s_axi_arready = st.arready;
    assign s_axi_rvalid  = st.rvalid;
    assign s_axi_rdata   = st.rdata;
    assign s_axi_rresp   = st.rresp;
    assign irq           = st.irq;

    ////////////////////////////////////////////////////////////////////
    // assertions
    a_stop_holds: assert property (@(posedge aclk)
        disable iff (!aresetn)
        !st.ctrl.run |=> st.count == $past(st.count) || $past(wr_go))
        else $error("count moved while stopped");
    a_idle_halt: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (idle_mode && st.ctrl.idle_stop_select && !wr_go)
        |=> $stable(st.count))
        else $error("count moved in idle with stop select");
    a_gate_low: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (st.ctrl.gated_accumulate_enable && !st.ctrl.clock_source_select
         && !st.ext_sync[1] && !wr_go) |=> $stable(st.count))
        else $error("count moved with gate low");
    a_match_wrap: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (tick && st.count == st.period_value && !wr_go)
        |=> st.count == 16'h0000 && st.status[gpt_pkg::ST_MATCH])
        else $error("period match did not wrap and flag");
    a_match_wins: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (tick && st.count == st.period_value)
        |=> st.status[gpt_pkg::ST_MATCH])
        else $error("match flag lost to a same-cycle clear");
    a_prescale_one: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (st.ctrl.prescale_select == 2'h0 && active && src_tick) |-> tick)
        else $error("1:1 prescale missed a tick");
    a_write_ps_clr: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (wr_go && st.ctrl.run
         && st.waddr == gpt_pkg::ADDR_W'(gpt_pkg::OFF_CONTROL))
        |=> st.prescale == 8'h00)
        else $error("control write did not reset prescaler");
    a_ctrl_zeros: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (ctrl_rd & ~gpt_pkg::CTRL_WMASK) == 16'h0000)
        else $error("unimplemented control bits not zero");
    a_gate_edge: assert property (@(posedge aclk)
        disable iff (!aresetn)
        gate_fall |=> st.status[gpt_pkg::ST_GATE])
        else $error("gate falling edge not flagged");
    a_irq_level: assert property (@(posedge aclk)
        disable iff (!aresetn)
        irq == |(st.status & st.mask))
        else $error("interrupt level wrong");
    a_ext_src: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (st.ctrl.clock_source_select && !ext_edge) |-> !tick)
        else $error("external mode ticked without an edge");
    c_match: cover property (@(posedge aclk)
        tick && st.count == st.period_value);
    c_gate: cover property (@(posedge aclk) gate_fall);
    c_ext: cover property (@(posedge aclk)
        st.ctrl.clock_source_select && tick);
endmodule : gpt_timer

/* shared/gpt_pkg.sv */
// constants and carrier types for the gated prescaled 16-bit timer
// assumes a single 50 MHz clock domain and an AXI4-Lite register slave
package gpt_pkg;
    // register byte offsets
    localparam logic [3:0] OFF_CONTROL = 4'h0;
    localparam logic [3:0] OFF_COUNT   = 4'h4;
    localparam logic [3:0] OFF_PERIOD  = 4'h8;
    localparam logic [3:0] OFF_STATUS  = 4'hC;
    localparam logic [4:0] OFF_MASK    = 5'h10;
    localparam int         ADDR_W      = 5;
    // control field positions
    localparam int BIT_RUN   = 15;
    localparam int BIT_IDLE  = 13;
    localparam int BIT_GATE  = 6;
    localparam int BIT_PS_HI = 5;
    localparam int BIT_PS_LO = 4;
    localparam int BIT_SYNC  = 2;
    localparam int BIT_CS    = 1;
    localparam logic [15:0] CTRL_WMASK = 16'hA076;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] PERIOD_RESET = 16'hFFFF;
    // status bits: match event, gate falling event
    localparam int ST_MATCH = 0;
    localparam int ST_GATE  = 1;
    localparam int ST_W     = 2;
    // prescale terminal counts (ratio minus one)
    localparam logic [7:0] PS_DIV1   = 8'h00;
    localparam logic [7:0] PS_DIV8   = 8'h07;
    localparam logic [7:0] PS_DIV64  = 8'h3F;
    localparam logic [7:0] PS_DIV256 = 8'hFF;
    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic        run;
        logic        idle_stop_select;
        logic        gated_accumulate_enable;
        logic [1:0]  prescale_select;
        logic        external_sync_select;
        logic        clock_source_select;
    } gpt_ctrl_t;

    typedef struct packed {
        gpt_ctrl_t         ctrl;
        logic [15:0]       period_value;
        logic [15:0]       count;
        logic [7:0]        prescale;
        logic              half_clk;
        logic [1:0]        ext_sync;
        logic              ext_prev;
        logic              gate_prev;
        logic [ST_W-1:0]   status;
        logic [ST_W-1:0]   mask;
        logic              irq;
        logic              awready;
        logic              wready;
        logic              have_aw;
        logic              have_w;
        logic [ADDR_W-1:0] waddr;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
    } gpt_state_t;
endpackage : gpt_pkg

/* verification/gpt_pin_model.sv */
// pin model: clock bursts or gate levels on the external count input
// assumes the bench calls its tasks; the pin rests low between bursts
module gpt_pin_model (
    input  wire logic aclk,
    output logic      pin
);
    timeunit 1ns;
    timeprecision 1ps;
    initial pin = 1'b0;
    // burst of rising edges, each level held a number of cycles
    task automatic pulses(input int n, input int hi, input int lo);
        for (int i = 0; i < n; i++) begin
            repeat (lo) @(posedge aclk);
            pin <= 1'b1;
            repeat (hi) @(posedge aclk);
            pin <= 1'b0;
        end
    endtask : pulses
    // gate level changed just after an edge
    task automatic level(input logic v);
        @(posedge aclk);
        pin <= v;
    endtask : level
endmodule : gpt_pin_model

/* verification/gpt_timer_tb.sv */
// self-checking bench for the timer: bus tasks, pin model, control model
// assumes gpt_pkg and the pin model are compiled first
module gpt_timer_tb;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(g, e) begin \
    n_checks++; \
    if ((g) !== (e)) begin \
        bad_count++; \
        $display("[FAIL] %0t got %0h exp %0h", $time, (g), (e)); \
    end \
end
    localparam logic [4:0]  CTL  = 5'(gpt_pkg::OFF_CONTROL);
    localparam logic [4:0]  CNT  = 5'(gpt_pkg::OFF_COUNT);
    localparam logic [4:0]  PER  = 5'(gpt_pkg::OFF_PERIOD);
    localparam logic [4:0]  STA  = 5'(gpt_pkg::OFF_STATUS);
    localparam logic [4:0]  MSK  = gpt_pkg::OFF_MASK;
    localparam logic [31:0] RUN  = 32'h1 << gpt_pkg::BIT_RUN;
    localparam logic [31:0] IDLE = 32'h1 << gpt_pkg::BIT_IDLE;
    localparam logic [31:0] GATE = 32'h1 << gpt_pkg::BIT_GATE;
    localparam logic [31:0] CS   = 32'h1 << gpt_pkg::BIT_CS;
    localparam logic [31:0] SYN  = 32'h1 << gpt_pkg::BIT_SYNC;
    logic        aclk = 1'b0, aresetn = 1'b0, idle_mode = 1'b0;
    logic [4:0]  s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [1:0]  s_axi_bresp, s_axi_rresp, br;
    logic        external_count_input;
    int          bad_count = 0, n_checks = 0, m_ctl = 0;
    // device under test and the pin beside it
    gpt_timer i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .external_count_input, .idle_mode, .irq);
    gpt_pin_model i_pin (.aclk, .pin(external_count_input));
    // 50 MHz clock
    always #10 aclk = ~aclk;
    // window check: a value within tolerance passes as itself
    function automatic logic [31:0] fit(logic [31:0] g, int e, int t);
        if (g + t >= e && g <= e + t)
            return g;
        return 32'(e);
    endfunction : fit
    // bus write; the model keeps the writable control bits
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge aclk);
            t++;
            if (s_axi_awready === 1'b1)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1)
                s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && t < 50);
        br = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (t >= 50)
            bad_count++;
        if (a == CTL && br === gpt_pkg::RESP_OKAY)
            m_ctl = int'(d & 32'(gpt_pkg::CTRL_WMASK));
    endtask : wr
    // bus read
    task automatic rd(input logic [4:0] a, output logic [31:0] v,
                      output logic [1:0] r);
        int t;
        t = 0;
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge aclk);
            t++;
            if (s_axi_arready === 1'b1)
                s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && t < 50);
        v = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (t >= 50)
            bad_count++;
    endtask : rd
    // read and compare within a tolerance
    task automatic chk(input logic [4:0] a, input int e, input int t);
        logic [31:0] v;
        logic [1:0]  r;
        rd(a, v, r);
        `CHK(v, fit(v, e, t))
    endtask : chk
    task automatic tend(input string s);
        $display("test %s done", s);
    endtask : tend
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : test_done
    // watchdog well beyond the expected run of some 14k cycles
    initial begin
        #1000000;
        bad_count++;
        test_done();
    end
    // main sequence
    initial begin
        int          div [4] = '{1, 8, 64, 256};
        logic [31:0] ectl [3] = '{RUN | CS | SYN, RUN | CS,
                                  RUN | CS | GATE | 32'h10};
        int          en [3] = '{10, 7, 16};
        int          ex [3] = '{10, 7, 2};
        logic [31:0] rv;
        logic [1:0]  rr;
        void'($urandom(99244));
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        chk(CTL, 0, 0);
        chk(CNT, 0, 0);
        chk(PER, 32'hFFFF, 0);
        chk(STA, 0, 0);
        chk(MSK, 0, 0);
        rd(5'h14, rv, rr);
        `CHK(rr, gpt_pkg::RESP_SLVERR)
        `CHK(rv, 32'h0)
        wr(5'h14, 32'hFFFF);
        `CHK(br, gpt_pkg::RESP_SLVERR)
        tend("reset");
        wr(CTL, 32'h7FFF);
        chk(CTL, m_ctl, 0);
        rv = $urandom & 32'hFFFF;
        wr(PER, rv);
        chk(PER, int'(rv), 0);
        rv = $urandom & 32'hFFFF;
        wr(CNT, rv);
        repeat (60) @(posedge aclk);
        chk(CNT, int'(rv), 0);
        tend("control");
        wr(PER, 32'hFFFF);
        for (int i = 0; i < 4; i++) begin
            wr(CNT, 0);
            wr(CTL, RUN | (32'(i) << 4));
            repeat (40 * div[i]) @(posedge aclk);
            wr(CTL, 0);
            chk(CNT, 20, 2);
        end
        tend("prescale");
        for (int i = 0; i < 3; i++) begin
            wr(CNT, 0);
            wr(CTL, ectl[i]);
            i_pin.pulses(en[i], 3, 3);
            repeat (6) @(posedge aclk);
            wr(CTL, 0);
            chk(CNT, ex[i], 0);
        end
        tend("external");
        wr(STA, 32'h3);
        wr(CNT, 0);
        wr(CTL, RUN | GATE);
        repeat (40) @(posedge aclk);
        chk(CNT, 0, 0);
        i_pin.level(1'b1);
        repeat (200) @(posedge aclk);
        i_pin.level(1'b0);
        repeat (6) @(posedge aclk);
        wr(CTL, 0);
        chk(CNT, 100, 3);
        chk(STA, 2, 0);
        tend("gate");
        wr(CNT, 0);
        idle_mode <= 1'b1;
        wr(CTL, RUN | IDLE);
        repeat (100) @(posedge aclk);
        chk(CNT, 0, 0);
        wr(CTL, RUN);
        repeat (100) @(posedge aclk);
        wr(CTL, 0);
        chk(CNT, 50, 3);
        idle_mode <= 1'b0;
        tend("idle");
        wr(STA, 32'h3);
        wr(PER, 32'h4);
        wr(CNT, 0);
        wr(CTL, RUN);
        repeat (30) @(posedge aclk);
        `CHK(irq, 1'b0)
        chk(STA, 1, 0);
        wr(MSK, 32'h1);
        repeat (2) @(posedge aclk);
        `CHK(irq, 1'b1)
        chk(CNT, 2, 2);
        wr(PER, 32'h0);
        wr(CNT, 0);
        repeat (4) wr(STA, 32'h1);
        chk(STA, 1, 0);
        wr(CTL, 0);
        wr(STA, 32'h1);
        repeat (2) @(posedge aclk);
        `CHK(irq, 1'b0)
        chk(STA, 0, 0);
        tend("period");
        test_done();
    end
endmodule : gpt_timer_tb
